// ### rlp_pkg.sv
// Constants and types for the repeater low-power substate block
package rlp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_PERIOD_PS = 40000;
  localparam int FS_UI_PS      = 83333;
  localparam int LS_UI_PS      = 666667;
  localparam int K_WAKE_UI     = 8;
  localparam int EOP_SE0_UI    = 2;
  localparam int EOP_J_UI      = 1;
  localparam int WAKE_WAIT_US  = 1000;
  localparam int WAKE_ABORT_NS = 2000;
  localparam int LINK_ECHO_CYC = 2;
  localparam int CNT_W         = 20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RLP_ACTIVE,
    RLP_IDLE,
    RLP_RESUME,
    RLP_EOR,
    RLP_WAKE,
    RLP_WAKE_WAIT,
    RLP_WAKE_ABORT,
    RLP_DISC
  } rlp_state_t;

  typedef struct packed {
    logic plus;
    logic minus;
  } rlp_pair_t;

  typedef struct packed {
    rlp_pair_t val;
    rlp_pair_t oe_n;
  } rlp_drive_t;

  typedef struct packed {
    rlp_state_t             state;
    rlp_pair_t              link_s1;
    rlp_pair_t              link_s2;
    rlp_pair_t              legacy_downstream_port_s1;
    rlp_pair_t              legacy_downstream_port_s2;
    logic [CNT_W-1:0]       cnt;
    logic                   legacy_downstream_port_was_k;
    rlp_drive_t             link_drv;
    rlp_drive_t             legacy_downstream_port_drv;
    logic                   forwarding_mode;
    logic                   se_rx_en;
    logic                   hs_xcvr_en;
    logic                   to_active_idle;
    logic                   to_reset;
    logic                   to_default;
  } rlp_regs_t;

  // Cycles covering n unit intervals, rounded up
  function automatic int rlp_ui_cycles(input int ui_ps, input int n);
    rlp_ui_cycles = (ui_ps * n + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : rlp_ui_cycles

endpackage : rlp_pkg

// ### rlp_sleep.sv
// Repeater low-power substate machine: idle, host resume, remote wake
`timescale 1ns/1ns

// What this block does
// - In low power the repeater runs non-forwarding; forwarding only in active.
// - In sleep idle keep single-ended receivers on, high-speed off.
// - Resume seen on the host-facing link moves idle to host resume.
// - Remote wake on the legacy port moves idle to remote wake.
// - Reset message goes to reset; disconnect announcement goes to default.
// - Drive legacy resume while link resume lasts; stop at end of resume.
// - After end of resume and legacy resume done, go to active idle.
// - Forward legacy remote wake onto the link without added delay.
// - Drive legacy resume during host resume; end link wake on resume.
// - Start of resume moves wake to host resume; no K returns low power.
// - With no host resume, release line plus and hold line minus low.
// - Legacy K to SE0 during wake drives disconnect one on the link.
// - Disconnect announcement in remote wake moves to default.
module rlp_sleep
  import rlp_pkg::*;
#(
  parameter int WAKE_WAIT_US_P  = WAKE_WAIT_US,
  parameter int WAKE_ABORT_NS_P = WAKE_ABORT_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sleep_enter,
  input  wire logic       reset_msg,
  input  wire logic       disc_announce,
  input  wire logic       ls_mode,
  input  wire rlp_pair_t  link_in,
  input  wire rlp_pair_t  legacy_downstream_port_in,
  output rlp_drive_t      link_drv,
  output rlp_drive_t      legacy_downstream_port_drv,
  output logic            forwarding_mode,
  output logic            se_rx_en,
  output logic            hs_xcvr_en,
  output logic            to_active_idle,
  output logic            to_reset,
  output logic            to_default,
  output rlp_state_t      sleep_state
);

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int FS_K_CYC   = rlp_ui_cycles(FS_UI_PS, K_WAKE_UI);
  localparam int LS_K_CYC   = rlp_ui_cycles(LS_UI_PS, K_WAKE_UI);
  localparam int FS_SE0_CYC = rlp_ui_cycles(FS_UI_PS, EOP_SE0_UI);
  localparam int LS_SE0_CYC = rlp_ui_cycles(LS_UI_PS, EOP_SE0_UI);
  localparam int FS_J_CYC   = rlp_ui_cycles(FS_UI_PS, EOP_J_UI);
  localparam int LS_J_CYC   = rlp_ui_cycles(LS_UI_PS, EOP_J_UI);
  localparam int WAIT_CYC   = WAKE_WAIT_US_P * 1000 / CLK_PERIOD_NS;
  localparam int ABORT_CYC  =
    (WAKE_ABORT_NS_P + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam rlp_drive_t RELEASED = '{val: '0, oe_n: 2'h3};

  // ----------------------------------------------------------------
  // Slow K level of a pair: minus high (FS), plus high (LS)
  // ----------------------------------------------------------------
  function automatic rlp_pair_t k_level(input logic ls);
    k_level = ls ? 2'h2 : 2'h1;
  endfunction : k_level

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rlp_regs_t        r;
  rlp_regs_t        next_r;
  logic [CNT_W-1:0] k_lim;
  logic [CNT_W-1:0] se0_lim;
  logic [CNT_W-1:0] eop_lim;
  logic             link_k;
  logic             legacy_downstream_port_k;
  logic             legacy_downstream_port_se0;
  logic             legacy_downstream_port_j;

  always_comb begin
    k_lim   = ls_mode ? CNT_W'(LS_K_CYC) : CNT_W'(FS_K_CYC);
    se0_lim = ls_mode ? CNT_W'(LS_SE0_CYC) : CNT_W'(FS_SE0_CYC);
    eop_lim = se0_lim +
              (ls_mode ? CNT_W'(LS_J_CYC) : CNT_W'(FS_J_CYC));
  end

  // ----------------------------------------------------------------
  // Line decode from synchronised pins
  // ----------------------------------------------------------------
  always_comb begin
    // Slow K on the link is line minus high (FS) or line plus (LS)
    link_k   = ls_mode ? r.link_s2.plus : r.link_s2.minus;
    legacy_downstream_port_k   = ls_mode ? (r.legacy_downstream_port_s2.plus & ~r.legacy_downstream_port_s2.minus)
                       : (r.legacy_downstream_port_s2.minus & ~r.legacy_downstream_port_s2.plus);
    legacy_downstream_port_se0 = ~r.legacy_downstream_port_s2.plus & ~r.legacy_downstream_port_s2.minus;
    legacy_downstream_port_j   = ~legacy_downstream_port_k & ~legacy_downstream_port_se0;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r                = r;
    next_r.link_s1        = link_in;
    next_r.link_s2        = r.link_s1;
    next_r.legacy_downstream_port_s1        = legacy_downstream_port_in;
    next_r.legacy_downstream_port_s2        = r.legacy_downstream_port_s1;
    next_r.to_active_idle = 1'b0;
    next_r.to_reset       = 1'b0;
    next_r.to_default     = 1'b0;
    next_r.se_rx_en       = 1'b1;
    next_r.link_drv       = RELEASED;
    next_r.legacy_downstream_port_drv       = RELEASED;
    next_r.cnt            = r.cnt + CNT_W'(1);

    case (r.state)
      RLP_ACTIVE: begin
        // Long K while awake is wake or resume, not a packet
        if (sleep_enter) begin
          next_r.state = RLP_IDLE;
          next_r.cnt   = '0;
        end else if (link_k || legacy_downstream_port_k) begin
          if (r.cnt >= k_lim) begin
            next_r.state = link_k ? RLP_RESUME : RLP_WAKE;
            next_r.legacy_downstream_port_was_k = 1'b0;
            next_r.cnt   = '0;
          end
        end else begin
          next_r.cnt = '0;
        end
      end

      RLP_IDLE: begin
        next_r.cnt = '0;
        if (reset_msg) begin
          next_r.to_reset = 1'b1;
          next_r.state    = RLP_ACTIVE;
        end else if (disc_announce) begin
          next_r.to_default = 1'b1;
          next_r.state      = RLP_ACTIVE;
        end else if (link_k) begin
          next_r.state = RLP_RESUME;
        end else if (legacy_downstream_port_k) begin
          next_r.state      = RLP_WAKE;
          next_r.legacy_downstream_port_was_k = 1'b0;
        end
      end

      RLP_RESUME: begin
        next_r.cnt = '0;
        if (link_k) begin
          // Legacy K: minus high for FS, plus high for LS
          next_r.legacy_downstream_port_drv.val  = k_level(ls_mode);
          next_r.legacy_downstream_port_drv.oe_n = 2'h0;
        end else begin
          // Link K gone: end of resume seen
          next_r.state         = RLP_EOR;
          next_r.legacy_downstream_port_drv.val  = 2'h0;
          next_r.legacy_downstream_port_drv.oe_n = 2'h0;
        end
      end

      RLP_EOR: begin
        // Legacy end of resume: SE0, then J, then hand back
        next_r.legacy_downstream_port_drv.oe_n = 2'h0;
        if (r.cnt < se0_lim) begin
          next_r.legacy_downstream_port_drv.val = 2'h0;
        end else begin
          next_r.legacy_downstream_port_drv.val = ~k_level(ls_mode);
        end
        if (r.cnt >= eop_lim) begin
          next_r.legacy_downstream_port_drv      = RELEASED;
          next_r.to_active_idle = 1'b1;
          next_r.state         = RLP_ACTIVE;
          next_r.cnt           = '0;
        end
      end

      RLP_WAKE: begin
        next_r.cnt = '0;
        if (legacy_downstream_port_k) begin
          next_r.legacy_downstream_port_was_k = 1'b1;
          // Mirror legacy K straight onto the link
          next_r.link_drv.val  = k_level(ls_mode);
          next_r.link_drv.oe_n = ~k_level(ls_mode);
        end
        if (disc_announce) begin
          next_r.to_default = 1'b1;
          next_r.state      = RLP_ACTIVE;
          next_r.link_drv   = RELEASED;
        end else if (legacy_downstream_port_se0 && r.legacy_downstream_port_was_k) begin
          next_r.state = RLP_DISC;
        end else if (legacy_downstream_port_j && r.legacy_downstream_port_was_k) begin
          // Device wake done: release link, watch for host resume
          next_r.state    = RLP_WAKE_WAIT;
          next_r.link_drv = RELEASED;
        end
      end

      RLP_WAKE_WAIT: begin
        // Our own wake K stays in the synchroniser for two cycles
        // after release; it must not pass for host resume
        if (disc_announce) begin
          next_r.to_default = 1'b1;
          next_r.state      = RLP_ACTIVE;
        end else if (link_k && r.cnt >= CNT_W'(LINK_ECHO_CYC)) begin
          next_r.state = RLP_RESUME;
          next_r.cnt   = '0;
        end else if (legacy_downstream_port_se0) begin
          next_r.state = RLP_DISC;
        end else if (r.cnt >= CNT_W'(WAIT_CYC)) begin
          next_r.state          = RLP_WAKE_ABORT;
          next_r.cnt            = '0;
          next_r.link_drv.val   = 2'h0;
          next_r.link_drv.oe_n  = 2'h2;
        end
      end

      RLP_WAKE_ABORT: begin
        // Line minus held low to close the wake
        next_r.link_drv.val  = 2'h0;
        next_r.link_drv.oe_n = 2'h2;
        if (r.cnt >= CNT_W'(ABORT_CYC - 1)) begin
          next_r.link_drv = RELEASED;
          next_r.state    = RLP_IDLE;
          next_r.cnt      = '0;
        end
      end

      RLP_DISC: begin
        // Logic one on the non-K line until the host announces
        next_r.cnt           = '0;
        next_r.link_drv.val  = ~k_level(ls_mode);
        next_r.link_drv.oe_n = k_level(ls_mode);
        if (disc_announce) begin
          next_r.link_drv   = RELEASED;
          next_r.to_default = 1'b1;
          next_r.state      = RLP_ACTIVE;
        end
      end

      default: begin
        next_r.state = RLP_ACTIVE;
        next_r.cnt   = '0;
      end
    endcase

    // Mode follows the state being entered, so the first sleep
    // cycle is already non-forwarding with high speed off
    next_r.forwarding_mode = next_r.state == RLP_ACTIVE;
    next_r.hs_xcvr_en      = next_r.state == RLP_ACTIVE;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.state           <= RLP_ACTIVE;
      r.link_s1         <= '0;
      r.link_s2         <= '0;
      r.legacy_downstream_port_s1         <= '0;
      r.legacy_downstream_port_s2         <= '0;
      r.cnt             <= '0;
      r.legacy_downstream_port_was_k      <= 1'b0;
      r.link_drv        <= RELEASED;
      r.legacy_downstream_port_drv        <= RELEASED;
      r.forwarding_mode <= 1'b1;
      r.se_rx_en        <= 1'b1;
      r.hs_xcvr_en      <= 1'b1;
      r.to_active_idle  <= 1'b0;
      r.to_reset        <= 1'b0;
      r.to_default      <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    link_drv        = r.link_drv;
    legacy_downstream_port_drv        = r.legacy_downstream_port_drv;
    forwarding_mode = r.forwarding_mode;
    se_rx_en        = r.se_rx_en;
    hs_xcvr_en      = r.hs_xcvr_en;
    to_active_idle  = r.to_active_idle;
    to_reset        = r.to_reset;
    to_default      = r.to_default;
    sleep_state     = r.state;
  end

endmodule : rlp_sleep

// ### rlp_sleep_sva.sv
// Checker for the repeater low-power substate block
`timescale 1ns/1ns
module rlp_sleep_chk
  import rlp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sleep_enter,
  input wire logic       reset_msg,
  input wire logic       disc_announce,
  input wire logic       ls_mode,
  input wire rlp_drive_t link_drv,
  input wire rlp_drive_t legacy_downstream_port_drv,
  input wire logic       forwarding_mode,
  input wire logic       se_rx_en,
  input wire logic       hs_xcvr_en,
  input wire logic       to_active_idle,
  input wire logic       to_reset,
  input wire logic       to_default,
  input wire rlp_state_t sleep_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fwd_off_a: assert property (
    sleep_state != RLP_ACTIVE |-> !forwarding_mode) else $error("fwd on");
  idle_rx_a: assert property (
    sleep_state == RLP_IDLE |-> se_rx_en && !hs_xcvr_en) else $error("rx");
  enter_idle_a: assert property (
    sleep_state == RLP_ACTIVE && sleep_enter |=> sleep_state == RLP_IDLE)
    else $error("no idle");
  idle_reset_a: assert property (
    sleep_state == RLP_IDLE && reset_msg |=> to_reset && !to_default)
    else $error("no reset");
  idle_disc_a: assert property (
    sleep_state == RLP_IDLE && !reset_msg && disc_announce |=> to_default)
    else $error("no default");
  resume_k_a: assert property (
    sleep_state == RLP_RESUME && $past(sleep_state) == RLP_RESUME |->
    legacy_downstream_port_drv == {(ls_mode ? 2'b10 : 2'b01), 2'b00}) else $error("no K");
  eor_exit_a: assert property (
    sleep_state == RLP_EOR |-> ##[1:60] to_active_idle)
    else $error("eor stuck");
  abort_low_a: assert property (
    sleep_state == RLP_WAKE_ABORT && $past(sleep_state) == RLP_WAKE_ABORT
    && !ls_mode |-> !link_drv.oe_n.minus && !link_drv.val.minus)
    else $error("abort level");
  wake_disc_a: assert property (
    sleep_state inside {RLP_WAKE, RLP_WAKE_WAIT, RLP_DISC} && disc_announce
    |=> to_default && sleep_state == RLP_ACTIVE) else $error("no default");
  c_resume: cover property (sleep_state == RLP_RESUME);
  c_abort: cover property (sleep_state == RLP_WAKE_ABORT);
  c_disc: cover property (sleep_state == RLP_DISC);
endmodule : rlp_sleep_chk

// ### rlp_host_port.sv
// Model of the host-side downstream port facing the repeater
`timescale 1ns/1ns
module rlp_host_port
  import rlp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ls_mode,
  input  wire logic       resume_req,
  input  wire rlp_drive_t link_drv,
  output rlp_pair_t       link_line,
  output logic            disc_announce
);
  rlp_pair_t  k;
  logic [1:0] disc_cnt;
  assign k = ls_mode ? 2'b10 : 2'b01;
  // Repeater drive, else host resume K, else pull-down; rx always on
  assign link_line.plus = !link_drv.oe_n.plus ? link_drv.val.plus
                        : resume_req & k.plus;
  assign link_line.minus = !link_drv.oe_n.minus ? link_drv.val.minus
                         : resume_req & k.minus;
  // Disconnect one qualified over three cycles, then announced
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disc_cnt      <= 2'h0;
      disc_announce <= 1'b0;
    end else begin
      disc_cnt <= (link_line == ~k) ?
                  disc_cnt + {1'b0, disc_cnt != 2'h3} : 2'h0;
      disc_announce <= disc_cnt == 2'h2 && link_line == ~k;
    end
  end
endmodule : rlp_host_port

// ### rlp_sleep_tb.sv
// Self-checking bench for the repeater low-power substate block
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module rlp_sleep_tb
  import rlp_pkg::*;
;
  logic       clk, rst_n, sleep_enter, reset_msg, tb_disc, ls_mode;
  logic       resume_req, host_disc, fwd, se_rx, hs_en, ai, rs, df;
  rlp_pair_t  link_in, legacy_downstream_port_in, dev, k;
  rlp_drive_t link_drv, legacy_downstream_port_drv;
  rlp_state_t st;
  int         seed = 77, miscompares = 0, n_tests = 0, len;
  logic [2:0] exp_q[$];
  assign k = ls_mode ? 2'b10 : 2'b01;
  assign legacy_downstream_port_in.plus = !legacy_downstream_port_drv.oe_n.plus ? legacy_downstream_port_drv.val.plus : dev.plus;
  assign legacy_downstream_port_in.minus = !legacy_downstream_port_drv.oe_n.minus ? legacy_downstream_port_drv.val.minus : dev.minus;
  rlp_sleep #(.WAKE_WAIT_US_P(2), .WAKE_ABORT_NS_P(200)) u_rlp_sleep (
    .clk(clk), .rst_n(rst_n), .sleep_enter(sleep_enter),
    .reset_msg(reset_msg), .disc_announce(tb_disc | host_disc),
    .ls_mode(ls_mode), .link_in(link_in), .legacy_downstream_port_in(legacy_downstream_port_in),
    .link_drv(link_drv), .legacy_downstream_port_drv(legacy_downstream_port_drv), .forwarding_mode(fwd),
    .se_rx_en(se_rx), .hs_xcvr_en(hs_en), .to_active_idle(ai),
    .to_reset(rs), .to_default(df), .sleep_state(st));
  rlp_host_port u_rlp_host_port (.clk(clk), .rst_n(rst_n), .ls_mode(ls_mode),
    .resume_req(resume_req), .link_drv(link_drv), .link_line(link_in),
    .disc_announce(host_disc));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic wait_state(input rlp_state_t s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) @(negedge clk);
    `CHK(st, s)
    if (st !== s) results();
  endtask : wait_state
  task automatic enter;
    @(posedge clk) sleep_enter <= 1'b1;
    @(posedge clk) sleep_enter <= 1'b0;
    wait_state(RLP_IDLE, 4);
    `CHK({fwd, hs_en, se_rx}, 3'b001)
  endtask : enter
  task automatic host_resume;
    len = 10 + $unsigned($random(seed)) % 30;
    @(posedge clk) resume_req <= 1'b1;
    wait_state(RLP_RESUME, 8);
    @(posedge clk) {reset_msg, sleep_enter} <= 2'($random(seed));
    repeat (len) @(negedge clk);
    `CHK(legacy_downstream_port_drv, {k, 2'b00})
    `CHK(link_drv.oe_n, 2'b11)
    exp_q.push_back(3'b100);
    @(posedge clk) resume_req <= 1'b0;
    {reset_msg, sleep_enter} <= 2'h0;
    wait_state(RLP_ACTIVE, 120);
    `CHK(legacy_downstream_port_drv.oe_n, 2'b11)
  endtask : host_resume
  task automatic wake;
    @(posedge clk) dev <= k;
    wait_state(RLP_WAKE, 8);
    repeat (2) @(negedge clk);
    `CHK(link_drv, {k, ~k})
  endtask : wake
  task automatic reset_out;
    exp_q.push_back(3'b010);
    @(posedge clk) reset_msg <= 1'b1;
    tb_disc <= 1'b1;
    @(posedge clk) reset_msg <= 1'b0;
    tb_disc <= 1'b0;
    wait_state(RLP_ACTIVE, 4);
  endtask : reset_out
  // ----------------------------------------------------------------
  // Pulse scoreboard
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rst_n && (ai | rs | df) === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({ai, rs, df}, exp_q.pop_front())
    end
  end
  initial begin
    {rst_n, sleep_enter, reset_msg, tb_disc, ls_mode, resume_req} = 6'h00;
    dev = 2'b10;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) ls_mode <= m[0];
      dev <= m[0] ? 2'b01 : 2'b10;
      enter();
      reset_out();
      enter();
      exp_q.push_back(3'b001);
      @(posedge clk) tb_disc <= 1'b1;
      @(posedge clk) tb_disc <= 1'b0;
      wait_state(RLP_ACTIVE, 4);
      enter();
      host_resume();
      enter();
      wake();
      @(posedge clk) dev <= ~k;
      wait_state(RLP_WAKE_WAIT, 8);
      host_resume();
      enter();
      wake();
      @(posedge clk) dev <= ~k;
      wait_state(RLP_WAKE_ABORT, 90);
      @(negedge clk);
      `CHK({link_drv.val.minus, link_drv.oe_n.minus}, 2'b00)
      wait_state(RLP_IDLE, 30);
      reset_out();
      enter();
      wake();
      exp_q.push_back(3'b001);
      @(posedge clk) dev <= 2'b00;
      wait_state(RLP_DISC, 8);
      @(negedge clk);
      `CHK(link_drv, {~k, k})
      wait_state(RLP_ACTIVE, 12);
      @(posedge clk) dev <= ~k;
      @(posedge clk) dev <= k;
      wait_state(RLP_WAKE, 200);
      `CHK({fwd, hs_en}, 2'b00)
      exp_q.push_back(3'b001);
      @(posedge clk) tb_disc <= 1'b1;
      dev <= ~k;
      @(posedge clk) tb_disc <= 1'b0;
      wait_state(RLP_ACTIVE, 4);
    end
    repeat (4) @(posedge clk);
    `CHK(exp_q.size(), 0)
    results();
  end
endmodule : rlp_sleep_tb
bind rlp_sleep rlp_sleep_chk u_rlp_sleep_chk (.clk(clk), .rst_n(rst_n),
  .sleep_enter(sleep_enter), .reset_msg(reset_msg),
  .disc_announce(disc_announce), .ls_mode(ls_mode), .link_drv(link_drv),
  .legacy_downstream_port_drv(legacy_downstream_port_drv), .forwarding_mode(forwarding_mode),
  .se_rx_en(se_rx_en), .hs_xcvr_en(hs_xcvr_en),
  .to_active_idle(to_active_idle), .to_reset(to_reset),
  .to_default(to_default), .sleep_state(sleep_state));
